// ---- design/pio_map.svh ----
// Register offsets, field positions and reset values of the parallel I/O port
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define PIO_AW 8
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PIO_DATA_OFS 8'h00
`define PIO_DIR_OFS 8'h04
`define PIO_PULL_OFS 8'h08
`define PIO_SLEW_OFS 8'h0c
`define PIO_DRV_OFS 8'h10
`define PIO_PSC_OFS 8'h14
`define PIO_IRQ_ST_OFS 8'h18
`define PIO_IRQ_MSK_OFS 8'h1c
`define PIO_FUNC_OFS 8'h20
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PIO_PSC_FLAG_BIT 3
`define PIO_PSC_ACK_BIT 2
`define PIO_PSC_SEL_BIT 0
`define PIO_FUNC_DBG_BIT 0
`define PIO_ST_RECOV_BIT 0
`define PIO_ST_WAKE_BIT 1
`define PIO_ST_W 2
`define PIO_REG_RST 8'h00
`define PIO_FUNC_RST 1'h1
`endif

// ---- design/pio_pkg.sv ----
// Types shared by the parallel I/O port files
package pio_pkg;
  `include "pio_map.svh"
  // ----------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               awvalid;
    logic [`PIO_AW-1:0] awaddr;
    logic               wvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bready;
    logic               arvalid;
    logic [`PIO_AW-1:0] araddr;
    logic               rready;
  } pio_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pio_axi_rsp_type;
  // ----------------------------------------------------------------
  // Stop mode tracking
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PS_RUN, PS_FULL, PS_PARTIAL, PS_RETAIN} pio_stop_type;
endpackage : pio_pkg

// ---- design/pio_pin_cell.sv ----
// Per-pin ownership, buffer and read-source logic
`timescale 1ns/1ps
module pio_pin_cell
  import pio_pkg::*;
#(
  parameter bit OUT_ONLY = 1'b0,
  parameter bit IN_ONLY  = 1'b0
) (
  // Port register bits
  input  wire logic dir,
  input  wire logic dat,
  input  wire logic pull_en,
  // Shared peripheral controls
  input  wire logic dig_en,
  input  wire logic dig_oe,
  input  wire logic dig_out,
  input  wire logic ana_en,
  // Synchronised pin level
  input  wire logic pin_lvl,
  // Pad controls and read value
  output logic      oe,
  output logic      out,
  output logic      ibuf_en,
  output logic      pull_on,
  output logic      rd_bit,
  output logic      periph_in
);
  logic dig_own;
  // Analog wins over digital, digital over the port
  always_comb begin
    dig_own   = dig_en && !ana_en;
    ibuf_en   = !ana_en && !OUT_ONLY; // RULE4 RULE6
    if (ana_en) begin
      oe = 1'b0; // RULE6 RULE7
    end else if (dig_en) begin
      oe = dig_oe; // RULE1 RULE5
    end else if (OUT_ONLY) begin
      oe = 1'b1;
    end else if (IN_ONLY) begin
      oe = 1'b0;
    end else begin
      oe = dir; // RULE3 RULE17
    end
    out       = dig_own ? dig_out : dat;
    pull_on   = pull_en && !oe && !ana_en && !OUT_ONLY;
    // Direction still picks the read source under a digital owner
    if (OUT_ONLY || (dir && !IN_ONLY)) begin
      rd_bit = dat; // RULE5 RULE17
    end else begin
      rd_bit = ibuf_en ? pin_lvl : 1'b0; // RULE6
    end
    periph_in = ibuf_en ? pin_lvl : 1'b0;
  end
endmodule : pio_pin_cell

// ---- design/pio_port.sv ----
// Parallel I/O port with shared-function priority, stop-mode pin retention and AXI4-Lite registers
// Summary of operation
// [RULE1] An enabled shared peripheral takes the pin and the port function on it is disabled.
// [RULE2] Reset clears direction and pullup bits, hands pins to the port and gives the output-only pin to debug.
// [RULE3] Each direction bit enables its output buffer and selects the source of its data read.
// [RULE4] Input buffers stay enabled except on analog pins and on the output-only pin.
// [RULE5] A shared digital function drives the buffer enable while direction still picks the read source.
// [RULE6] An analog function disables both buffers and an input-configured read returns 0.
// [RULE7] With digital and analog both enabled, the analog function controls the pin.
// [RULE8] Software should load the data latch before turning a pin to output.
// [RULE9] Pullup, slew and drive controls act independently of data and direction; the code disables the pullup while the output buffer is enabled.
// [RULE10] Full power-off stop returns all port registers and pins to reset defaults; the code keeps the recovery flag and the interrupt status and mask.
// [RULE11] Partial power-down stop holds every pin in latches as it was before entry; the code latches out, enable, pullup and input buffer, not slew and drive.
// [RULE12] After partial power-down software checks the flag, restores, then writes the acknowledge.
// [RULE13] State-retaining stop keeps all pin states and functions unchanged.
// [RULE14] The recovery flag in bit 3 sets on partial power-down exit and clears on reset.
// [RULE15] Writing 1 to acknowledge bit 2 clears the recovery flag and that bit reads 0.
// [RULE16] Select bit 0 picks retaining (0) or partial power-down (1) stop and takes only the first write.
// [RULE17] Direction 0 disables the driver and reads the pin, 1 enables it and reads the latch.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module pio_port
  import pio_pkg::*;
#(
  parameter int NPINS        = 6,
  parameter int OUT_ONLY_IDX = 4,
  parameter int IN_ONLY_IDX  = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Register bus
  input  wire pio_axi_req_type  axi_req,
  output pio_axi_rsp_type       axi_rsp,
  output logic                  irq,
  // Stop control from the core
  input  wire logic             stop_active,
  input  wire logic             stop_full_off,
  // Shared peripherals
  input  wire logic [NPINS-1:0] dig_en,
  input  wire logic [NPINS-1:0] dig_oe,
  input  wire logic [NPINS-1:0] dig_out,
  input  wire logic [NPINS-1:0] ana_en,
  output logic      [NPINS-1:0] periph_in,
  input  wire logic             bkgd_oe,
  input  wire logic             bkgd_out,
  output logic                  bkgd_own,
  // Pads
  input  wire logic [NPINS-1:0] pad_in,
  output logic      [NPINS-1:0] pad_out,
  output logic      [NPINS-1:0] pad_oe,
  output logic      [NPINS-1:0] pad_pullup,
  output logic      [NPINS-1:0] pad_slew,
  output logic      [NPINS-1:0] pad_drive,
  output logic      [NPINS-1:0] pad_ibuf_en
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NPINS < 1 || NPINS > 8 || OUT_ONLY_IDX >= NPINS || IN_ONLY_IDX >= NPINS || OUT_ONLY_IDX == IN_ONLY_IDX)
    $error("pio_port: pin count or special pin index out of range");

  localparam logic [NPINS-1:0] IN_MASK = ~(NPINS'(1) << IN_ONLY_IDX);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic               aw_v_r, aw_v_nxt, w_v_r, w_v_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [`PIO_AW-1:0] aw_a_r, aw_a_nxt;
  logic [7:0]         w_d_r, w_d_nxt;
  logic               w_s_r, w_s_nxt;
  logic [1:0]         bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic [NPINS-1:0]   dat_r, dat_nxt, dir_r, dir_nxt, pull_r, pull_nxt;
  logic [NPINS-1:0]   slew_r, slew_nxt, drv_r, drv_nxt;
  logic [NPINS-1:0]   h_out_r, h_out_nxt, h_oe_r, h_oe_nxt, h_pull_r, h_pull_nxt, h_ib_r, h_ib_nxt;
  logic               func_r, func_nxt, sel_r, sel_nxt, once_r, once_nxt, flag_r, flag_nxt;
  logic               hold_r, hold_nxt, stop_q_r, stop_q_nxt;
  logic [`PIO_ST_W-1:0] st_r, st_nxt, msk_r, msk_nxt;
  pio_stop_type       state_r, state_nxt;
  logic [NPINS-1:0]   sync1_r, sync2_r;

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  logic [NPINS-1:0] c_oe, c_out, c_ib, c_pull, c_rd, c_den, c_doe, c_dout;
  genvar gi;
  for (gi = 0; gi < NPINS; gi++) begin : g_pin
    // The output-only pin is owned by the debug function while func_r is set
    assign c_den[gi]  = (gi == OUT_ONLY_IDX) ? (dig_en[gi] || func_r) : dig_en[gi];
    assign c_doe[gi]  = (gi == OUT_ONLY_IDX && func_r) ? bkgd_oe : dig_oe[gi];
    assign c_dout[gi] = (gi == OUT_ONLY_IDX && func_r) ? bkgd_out : dig_out[gi];
    pio_pin_cell #(
      .OUT_ONLY(gi == OUT_ONLY_IDX),
      .IN_ONLY (gi == IN_ONLY_IDX)
    ) u_cell (
      .dir      (dir_r[gi]),
      .dat      (dat_r[gi]),
      .pull_en  (pull_r[gi]),
      .dig_en   (c_den[gi]),
      .dig_oe   (c_doe[gi]),
      .dig_out  (c_dout[gi]),
      .ana_en   (ana_en[gi]),
      .pin_lvl  (sync2_r[gi]),
      .oe       (c_oe[gi]),
      .out      (c_out[gi]),
      .ibuf_en  (c_ib[gi]),
      .pull_on  (c_pull[gi]),
      .rd_bit   (c_rd[gi]),
      .periph_in(periph_in[gi])
    );
  end

  // Pad out, enable, pullup and input buffer follow the live cells, or the latches while held; slew and drive follow their registers
  always_comb begin
    pad_out     = hold_r ? h_out_r : c_out; // RULE11
    pad_oe      = hold_r ? h_oe_r : c_oe; // RULE11
    pad_pullup  = hold_r ? h_pull_r : c_pull;
    pad_ibuf_en = hold_r ? h_ib_r : c_ib;
    pad_slew    = slew_r; // RULE9
    pad_drive   = drv_r; // RULE9
    bkgd_own    = func_r;
    irq         = |(st_r & msk_r);
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic       wr_go, wr_hit, rd_hit, psc_wr;
  logic [7:0] rd_val, wd;
  assign wr_go = aw_v_r && w_v_r && !bvalid_r;
  assign wd    = w_s_r ? w_d_r : 8'h00;
  assign psc_wr = wr_go && w_s_r && (aw_a_r == `PIO_PSC_OFS);

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (axi_req.araddr == `PIO_DATA_OFS) rd_val = 8'(c_rd); // RULE3
    else if (axi_req.araddr == `PIO_DIR_OFS) rd_val = 8'(dir_r & IN_MASK);
    else if (axi_req.araddr == `PIO_PULL_OFS) rd_val = 8'(pull_r);
    else if (axi_req.araddr == `PIO_SLEW_OFS) rd_val = 8'(slew_r);
    else if (axi_req.araddr == `PIO_DRV_OFS) rd_val = 8'(drv_r);
    else if (axi_req.araddr == `PIO_PSC_OFS) rd_val = 8'(flag_r) << `PIO_PSC_FLAG_BIT |
                                                      8'(sel_r) << `PIO_PSC_SEL_BIT; // RULE14 RULE15
    else if (axi_req.araddr == `PIO_IRQ_ST_OFS) rd_val = 8'(st_r);
    else if (axi_req.araddr == `PIO_IRQ_MSK_OFS) rd_val = 8'(msk_r);
    else if (axi_req.araddr == `PIO_FUNC_OFS) rd_val = 8'(func_r);
    else rd_hit = 1'b0;
  end

  // Write address hit
  assign wr_hit = aw_a_r == `PIO_DATA_OFS || aw_a_r == `PIO_DIR_OFS || aw_a_r == `PIO_PULL_OFS ||
                  aw_a_r == `PIO_SLEW_OFS || aw_a_r == `PIO_DRV_OFS || aw_a_r == `PIO_PSC_OFS ||
                  aw_a_r == `PIO_IRQ_ST_OFS || aw_a_r == `PIO_IRQ_MSK_OFS || aw_a_r == `PIO_FUNC_OFS;

  // ----------------------------------------------------------------
  // AXI4-Lite channel handling
  // ----------------------------------------------------------------
  assign axi_rsp = '{awready: !aw_v_r, wready: !w_v_r, bvalid: bvalid_r, bresp: bresp_r,
                     arready: !rvalid_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

  // Address and data are caught in either order; the response follows both
  always_comb begin
    {aw_v_nxt, aw_a_nxt, w_v_nxt, w_d_nxt, w_s_nxt} = {aw_v_r, aw_a_r, w_v_r, w_d_r, w_s_r};
    {bvalid_nxt, bresp_nxt, rvalid_nxt, rdata_nxt, rresp_nxt} = {bvalid_r, bresp_r, rvalid_r, rdata_r, rresp_r};
    if (axi_req.awvalid && !aw_v_r) begin
      aw_v_nxt = 1'b1;
      aw_a_nxt = axi_req.awaddr;
    end
    if (axi_req.wvalid && !w_v_r) begin
      w_v_nxt = 1'b1;
      w_d_nxt = axi_req.wdata[7:0];
      w_s_nxt = axi_req.wstrb[0];
    end
    if (wr_go) begin
      aw_v_nxt = 1'b0;
      w_v_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
    end else if (bvalid_r && axi_req.bready) begin
      bvalid_nxt = 1'b0;
    end
    if (axi_req.arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_val};
      rresp_nxt = rd_hit ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
    end else if (rvalid_r && axi_req.rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus channel registers
  always_ff @(posedge clk) begin
    if (srst) begin
      {aw_v_r, aw_a_r, w_v_r, w_d_r, w_s_r, bvalid_r, rvalid_r, rdata_r} <= '0;
      bresp_r <= `PIO_RESP_OKAY;
      rresp_r <= `PIO_RESP_OKAY;
    end else begin
      {aw_v_r, aw_a_r, w_v_r, w_d_r, w_s_r} <= {aw_v_nxt, aw_a_nxt, w_v_nxt, w_d_nxt, w_s_nxt};
      {bvalid_r, bresp_r, rvalid_r, rdata_r, rresp_r} <= {bvalid_nxt, bresp_nxt, rvalid_nxt, rdata_nxt, rresp_nxt};
    end
  end

  // ----------------------------------------------------------------
  // Port registers, stop modes and retention
  // ----------------------------------------------------------------
  logic entry, leave, clr_ports;
  assign entry = stop_active && !stop_q_r;
  assign leave = !stop_active && stop_q_r;

  always_comb begin
    {dat_nxt, dir_nxt, pull_nxt, slew_nxt, drv_nxt, msk_nxt} = {dat_r, dir_r, pull_r, slew_r, drv_r, msk_r};
    {func_nxt, sel_nxt, once_nxt, flag_nxt, hold_nxt} = {func_r, sel_r, once_r, flag_r, hold_r};
    {h_out_nxt, h_oe_nxt, h_pull_nxt, h_ib_nxt} = {h_out_r, h_oe_r, h_pull_r, h_ib_r};
    state_nxt = state_r;
    stop_q_nxt = stop_active;
    clr_ports = 1'b0;
    st_nxt = st_r & ~((wr_go && aw_a_r == `PIO_IRQ_ST_OFS) ? wd[`PIO_ST_W-1:0] : '0);
    // Register writes
    if (wr_go && w_s_r) begin
      if (aw_a_r == `PIO_DATA_OFS) dat_nxt = wd[NPINS-1:0];
      else if (aw_a_r == `PIO_DIR_OFS) dir_nxt = wd[NPINS-1:0] & IN_MASK;
      else if (aw_a_r == `PIO_PULL_OFS) pull_nxt = wd[NPINS-1:0]; // RULE9
      else if (aw_a_r == `PIO_SLEW_OFS) slew_nxt = wd[NPINS-1:0];
      else if (aw_a_r == `PIO_DRV_OFS) drv_nxt = wd[NPINS-1:0];
      else if (aw_a_r == `PIO_IRQ_MSK_OFS) msk_nxt = wd[`PIO_ST_W-1:0];
      else if (aw_a_r == `PIO_FUNC_OFS) func_nxt = wd[`PIO_FUNC_DBG_BIT];
    end
    if (psc_wr && !once_r) begin
      sel_nxt = wd[`PIO_PSC_SEL_BIT]; // RULE16
      once_nxt = 1'b1;
    end
    if (psc_wr && wd[`PIO_PSC_ACK_BIT]) begin
      flag_nxt = 1'b0; // RULE15
      hold_nxt = 1'b0;
    end
    // Stop mode sequencing
    case (state_r)
      PS_RUN: begin
        if (entry && stop_full_off) begin
          state_nxt = PS_FULL;
          clr_ports = 1'b1; // RULE10
          hold_nxt = 1'b0; // Powered-off pins drop any unacknowledged hold RULE10
        end else if (entry && sel_r) begin
          state_nxt = PS_PARTIAL;
          hold_nxt = 1'b1; // RULE11
          {h_out_nxt, h_oe_nxt, h_pull_nxt, h_ib_nxt} = {pad_out, pad_oe, pad_pullup, pad_ibuf_en};
        end else if (entry) begin
          state_nxt = PS_RETAIN; // RULE13
        end
      end
      PS_PARTIAL: begin
        if (leave) begin
          state_nxt = PS_RUN;
          clr_ports = 1'b1;
          flag_nxt = 1'b1; // RULE14
          hold_nxt = 1'b1;
          st_nxt[`PIO_ST_RECOV_BIT] = 1'b1;
        end
      end
      default: begin
        if (leave) state_nxt = PS_RUN;
      end
    endcase
    if (leave) st_nxt[`PIO_ST_WAKE_BIT] = 1'b1;
    // Registers lost while powered down come back at reset values
    if (clr_ports) begin
      {dat_nxt, dir_nxt, pull_nxt, slew_nxt, drv_nxt} = {5{NPINS'(`PIO_REG_RST)}}; // RULE2 RULE10
      func_nxt = `PIO_FUNC_RST;
      sel_nxt = 1'b0;
      once_nxt = 1'b0;
    end
  end

  // Port, stop and retention registers
  always_ff @(posedge clk) begin
    if (srst) begin
      {dat_r, dir_r, pull_r, slew_r, drv_r} <= {5{NPINS'(`PIO_REG_RST)}}; // RULE2
      {h_out_r, h_oe_r, h_pull_r, h_ib_r, st_r, msk_r} <= '0;
      {sel_r, once_r, flag_r, hold_r, stop_q_r} <= '0; // RULE14
      func_r <= `PIO_FUNC_RST;
      state_r <= PS_RUN;
    end else begin
      {dat_r, dir_r, pull_r, slew_r, drv_r, msk_r} <= {dat_nxt, dir_nxt, pull_nxt, slew_nxt, drv_nxt, msk_nxt};
      {func_r, sel_r, once_r, flag_r, hold_r} <= {func_nxt, sel_nxt, once_nxt, flag_nxt, hold_nxt};
      {h_out_r, h_oe_r, h_pull_r, h_ib_r, st_r} <= {h_out_nxt, h_oe_nxt, h_pull_nxt, h_ib_nxt, st_nxt};
      state_r <= state_nxt;
      stop_q_r <= stop_q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  periph_owns_pin_a: assert property (!hold_r && dig_en[0] && !ana_en[0] |-> pad_oe[0] == dig_oe[0]) // RULE1 RULE5
    else $error("shared digital function does not own pin 0");
  reset_default_a: assert property ($fell(srst) |-> dir_r == '0 && pull_r == '0 && func_r && pad_pullup == '0) // RULE2
    else $error("port not at defaults after reset");
  dir_drives_oe_a: assert property (!hold_r && !c_den[0] && !ana_en[0] |-> pad_oe[0] == dir_r[0]) // RULE3 RULE17
    else $error("direction bit does not steer pin 0 driver");
  ibuf_gating_a: assert property (!hold_r |-> !pad_ibuf_en[OUT_ONLY_IDX] && pad_ibuf_en[0] == !ana_en[0]) // RULE4
    else $error("input buffer enable wrong");
  analog_wins_a: assert property (!hold_r && ana_en[0] |-> !pad_oe[0] && !pad_ibuf_en[0] && (dir_r[0] || !c_rd[0])) // RULE6 RULE7
    else $error("analog pin not isolated");
  full_off_reset_a: assert property (state_r == PS_FULL |-> dir_r == '0 && pad_pullup == '0 && !hold_r) // RULE10
    else $error("full power-off left port configured");
  partial_hold_a: assert property (hold_r && $past(hold_r) |-> $stable(pad_oe) && $stable(pad_out)) // RULE11
    else $error("held pin state changed");
  retain_stable_a: assert property (state_r == PS_RETAIN && $past(state_r) == PS_RETAIN && !$past(wr_go) |-> $stable(dir_r) && $stable(dat_r)) // RULE13
    else $error("retaining stop altered port state");
  flag_set_a: assert property (state_r == PS_PARTIAL && leave |=> flag_r && hold_r ##1 flag_r) // RULE14
    else $error("recovery flag not set on exit");
  ack_clear_a: assert property (psc_wr && wd[`PIO_PSC_ACK_BIT] && !(state_r == PS_PARTIAL && leave) |=> !flag_r) // RULE15
    else $error("acknowledge did not clear flag");
  write_once_a: assert property (psc_wr && once_r && !clr_ports |=> $stable(sel_r)) // RULE16
    else $error("stop select changed after first write");

  partial_cycle_c: cover property (state_r == PS_PARTIAL && leave ##[1:50] psc_wr && wd[`PIO_PSC_ACK_BIT]);
  full_off_c: cover property (state_r == PS_FULL ##[1:50] state_r == PS_RUN);
  irq_raise_c: cover property ($rose(irq));
endmodule : pio_port

// ---- verification/pio_pins_model.sv ----
// Board-side model of the port pins
`timescale 1ns/1ps
module pio_pins_model
  import pio_pkg::*;
#(
  parameter int NPINS = 6
) (
  // Pad drive from the port
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] pad_oe,
  input  wire logic [NPINS-1:0] pad_pullup,
  // Board level where nothing drives
  input  wire logic [NPINS-1:0] board_lvl,
  // Level seen at the pins
  output logic      [NPINS-1:0] pad_in
);
  // Port driver wins, then pullup, then the board
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : (pad_pullup[i] | board_lvl[i]);
    end
  end
endmodule : pio_pins_model

// ---- verification/pio_port_tb.sv ----
// Self-checking bench for the parallel I/O port
`timescale 1ns/1ps
module pio_port_tb
  import pio_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic            clk = 1'h0;
  logic            srst = 1'h1;
  pio_axi_req_type req = '0;
  pio_axi_rsp_type rsp;
  logic            irq;
  logic            own;
  logic            stop_act = 1'h0;
  logic            full_off = 1'h0;
  logic            bkgd_oe = 1'h0;
  logic [5:0]      dig_en = '0, dig_oe = '0, dig_out = '0, ana_en = '0;
  logic [5:0]      board = 6'h2a;
  logic [5:0]      pad_in, pad_out, pad_oe, pull, slew, drive, ibuf, per_in;
  logic [31:0]     rdat;
  logic [1:0]      resp;
  int              failures = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  pio_port pio_port_i (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp), .irq(irq),
    .stop_active(stop_act), .stop_full_off(full_off), .dig_en(dig_en), .dig_oe(dig_oe),
    .dig_out(dig_out), .ana_en(ana_en), .periph_in(per_in), .bkgd_oe(bkgd_oe), .bkgd_out(bkgd_oe),
    .bkgd_own(own), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pull),
    .pad_slew(slew), .pad_drive(drive), .pad_ibuf_en(ibuf));
  pio_pins_model pio_pins_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pull),
    .board_lvl(board), .pad_in(pad_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Write one register, holding each channel until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'h0;
    @(posedge clk);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        req.bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : wr
  // Read one register
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'h0;
    @(posedge clk);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid) begin
        rdat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask : rdc
  // Enter a stop and stay four cycles
  task automatic stop_for(input logic f);
    @(posedge clk);
    full_off <= f;
    stop_act <= 1'h1;
    repeat (4) @(posedge clk);
  endtask : stop_for
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    chk(32'(pad_oe), 32'h0);
    chk(32'(ibuf), 32'h2f);
    rdc(8'h04, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(8'h20, 32'h1);
    rdc(8'h00, 32'h2a);
    chk(32'({own, per_in}), 32'h6a);
    bkgd_oe <= 1'h1;
    @(posedge clk);
    chk(32'({pad_oe, pad_out[4]}), 32'h21);
    bkgd_oe <= 1'h0;
    $display("reset test done");
    wr(8'h20, 8'h00);
    wr(8'h00, 8'h15);
    wr(8'h04, 8'h3f);
    chk(32'(pad_oe), 32'h1f);
    chk(32'(pad_out[4:0]), 32'h15);
    rdc(8'h04, 32'h1f);
    rdc(8'h00, 32'h35);
    wr(8'h04, 8'h00);
    chk(32'(pad_oe), 32'h10);
    repeat (2) @(posedge clk);
    rdc(8'h00, 32'h3a);
    $display("direction test done");
    dig_en <= 6'h01;
    dig_oe <= 6'h01;
    wr(8'h04, 8'h01);
    chk(32'(pad_oe), 32'h11);
    chk(32'(pad_out[0]), 32'h0);
    rdc(8'h00, 32'h3b);
    dig_oe <= 6'h00;
    @(posedge clk);
    chk(32'(pad_oe), 32'h10);
    dig_oe <= 6'h01;
    ana_en <= 6'h01;
    board <= 6'h2b;
    wr(8'h04, 8'h00);
    chk(32'(pad_oe), 32'h10);
    chk(32'(ibuf), 32'h2e);
    rdc(8'h00, 32'h3a);
    chk(32'({own, per_in}), 32'h2a);
    dig_en <= 6'h00;
    ana_en <= 6'h00;
    board <= 6'h2a;
    $display("shared function test done");
    wr(8'h08, 8'h3f);
    wr(8'h0c, 8'h3f);
    wr(8'h10, 8'h2a);
    chk(32'(pull), 32'h2f);
    chk(32'({slew, drive}), 32'hfea);
    rdc(8'h00, 32'h3f);
    wr(8'h14, 8'h01);
    wr(8'h14, 8'h00);
    rdc(8'h14, 32'h1);
    $display("control test done");
    wr(8'h00, 8'h05);
    wr(8'h04, 8'h0f);
    stop_for(1'h0);
    chk(32'(pad_oe), 32'h1f);
    stop_act <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'({pad_oe, pad_out[3:0]}), 32'h1f5);
    rdc(8'h14, 32'h8);
    wr(8'h1c, 8'h00);
    chk(32'(irq), 32'h0);
    wr(8'h1c, 8'h03);
    chk(32'(irq), 32'h1);
    rdc(8'h18, 32'h3);
    wr(8'h20, 8'h00);
    wr(8'h00, 8'h05);
    wr(8'h04, 8'h0f);
    wr(8'h14, 8'h04);
    rdc(8'h14, 32'h0);
    chk(32'(pad_oe), 32'h1f);
    wr(8'h18, 8'h03);
    chk(32'(irq), 32'h0);
    $display("partial stop test done");
    stop_for(1'h0);
    chk(32'(pad_oe), 32'h1f);
    stop_act <= 1'h0;
    rdc(8'h04, 32'hf);
    rdc(8'h14, 32'h0);
    rdc(8'h18, 32'h2);
    wr(8'h18, 8'h02);
    wr(8'h08, 8'h3f);
    chk(32'(pull), 32'h20);
    stop_for(1'h1);
    chk(32'({pad_oe, pull}), 32'h0);
    stop_act <= 1'h0;
    rdc(8'h04, 32'h0);
    rdc(8'h20, 32'h1);
    wr(8'h14, 8'h01);
    rdc(8'h14, 32'h1);
    rd(8'h24);
    chk({rdat[29:0], resp}, 32'h2);
    wr(8'h3c, 8'hff);
    chk(32'(resp), 32'h2);
    $display("stop and error test done");
    test_done();
  end
endmodule : pio_port_tb
